// File: include/irm_pkg.sv
package irm_pkg;
  localparam logic [2:0] ADDR_WIDTH_REG = 3'h0;
  localparam logic [2:0] ADDR_GAP_REG = 3'h1;
  localparam logic [2:0] ADDR_COUNT_LO = 3'h2;
  localparam logic [2:0] ADDR_CONTROL = 3'h3;
  localparam logic [2:0] ADDR_COUNT_HI = 3'h4;
  localparam int BIT_CARRIER = 0;
  localparam int BIT_LONG = 1;
  localparam int BIT_CONT = 2;
  localparam int BIT_CLR_IRQ = 3;
  localparam int BIT_WDT = 4;
  localparam logic [7:0] CONTROL_STORE_MASK = 8'h07;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] WIDTH_RESET = 8'h00;
  localparam logic [9:0] COUNT_RESET = 10'h000;
  // timer loads value+1 and ends at zero, giving value+2 cycles
  localparam logic [8:0] TIMER_EXTRA = 9'h001;
  localparam int EXTRA_CYCLES = 2;
  typedef enum logic [1:0] {
    IRM_IDLE = 2'b00,
    IRM_ON = 2'b01,
    IRM_OFF = 2'b10
  } irm_state_t;
endpackage

// File: rtl/irm_modulator.sv
`timescale 1ns/1ps
module irm_modulator (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic CE_I,
  input wire logic [2:0] DREG_ADDR_I,
  input wire logic [7:0] DREG_WDATA_I,
  input wire logic DREG_WR_I,
  input wire logic DREG_RD_I,
  output logic [7:0] DREG_RDATA_O,
  output logic MOD_OUT_N_O,
  output logic BURST_DONE_IRQ_O,
  output logic WATCHDOG_RELOAD_O
);
  irm_pkg::irm_state_t state_reg, state_next;
  logic [7:0] width_reg, width_next;
  logic [7:0] gap_reg, gap_next;
  logic [7:0] control_reg, control_next;
  logic [1:0] count_hi_reg, count_hi_next;
  logic [9:0] count_reg, count_next;
  logic [8:0] timer_reg, timer_next;
  logic [1:0] phase_reg, phase_next;
  logic irq_reg, irq_next;
  logic out_n_reg, out_n_next;
  logic wdt_reg, wdt_next;
  logic [7:0] rdata_reg, rdata_next;
  logic wr_ctrl, load_count, timer_done, finish;
  logic carrier_enable, long_pulse_enable, continuous_enable;

  // register-port decode; counter low byte write is the burst trigger
  assign wr_ctrl = DREG_WR_I && (DREG_ADDR_I == irm_pkg::ADDR_CONTROL);
  assign load_count = DREG_WR_I && (DREG_ADDR_I == irm_pkg::ADDR_COUNT_LO);
  assign carrier_enable = control_reg[irm_pkg::BIT_CARRIER];
  assign long_pulse_enable = control_reg[irm_pkg::BIT_LONG];
  assign continuous_enable = control_reg[irm_pkg::BIT_CONT];
  assign timer_done = (timer_reg == 9'h000);
  // last pulse ends: continuous mode never finishes
  assign finish = (state_reg == irm_pkg::IRM_ON) && timer_done && !continuous_enable
    && (count_reg == 10'h001);

  // register file next values
  always_comb
  begin
    width_next = width_reg;
    gap_next = gap_reg;
    control_next = control_reg;
    count_hi_next = count_hi_reg;
    wdt_next = 1'b0;
    rdata_next = rdata_reg;
    if (DREG_WR_I)
    begin
      case (DREG_ADDR_I)
        irm_pkg::ADDR_WIDTH_REG: width_next = DREG_WDATA_I;
        irm_pkg::ADDR_GAP_REG: gap_next = DREG_WDATA_I;
        irm_pkg::ADDR_CONTROL:
        begin
          // strobes and reserved bits are never stored
          control_next = DREG_WDATA_I & irm_pkg::CONTROL_STORE_MASK;
          wdt_next = DREG_WDATA_I[irm_pkg::BIT_WDT];
        end
        irm_pkg::ADDR_COUNT_HI: count_hi_next = DREG_WDATA_I[1:0];
        default: width_next = width_reg;
      endcase
    end
    if (DREG_RD_I)
    begin
      case (DREG_ADDR_I)
        irm_pkg::ADDR_WIDTH_REG: rdata_next = width_reg;
        irm_pkg::ADDR_GAP_REG: rdata_next = gap_reg;
        irm_pkg::ADDR_COUNT_LO: rdata_next = count_reg[7:0];
        irm_pkg::ADDR_CONTROL: rdata_next = control_reg;
        irm_pkg::ADDR_COUNT_HI: rdata_next = {6'h00, count_reg[9:8]};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // pulse sequencer: timer runs value+1 down to zero, one step per enabled cycle
  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    timer_next = timer_reg;
    phase_next = phase_reg + 2'h1;
    irq_next = irq_reg;
    if (wr_ctrl && DREG_WDATA_I[irm_pkg::BIT_CLR_IRQ])
      irq_next = 1'b0;
    if (load_count)
    begin
      // a zero load is forbidden to software and wraps to 1024 pulses
      state_next = irm_pkg::IRM_ON;
      count_next = {count_hi_reg, DREG_WDATA_I};
      timer_next = {1'b0, width_reg} + irm_pkg::TIMER_EXTRA;
      phase_next = 2'h0;
      irq_next = 1'b0;
    end
    else
    begin
      case (state_reg)
        irm_pkg::IRM_ON:
        begin
          if (!timer_done)
            timer_next = timer_reg - 9'h001;
          else
          begin
            if (!continuous_enable)
              count_next = count_reg - 10'h001;
            timer_next = {1'b0, width_reg} + irm_pkg::TIMER_EXTRA;
            if (finish)
            begin
              state_next = irm_pkg::IRM_IDLE;
              irq_next = 1'b1;
            end
            else if (!long_pulse_enable)
            begin
              state_next = irm_pkg::IRM_OFF;
              timer_next = {1'b0, gap_reg} + irm_pkg::TIMER_EXTRA;
            end
            // long pulse: stays active, gap register ignored
          end
        end
        irm_pkg::IRM_OFF:
        begin
          if (!timer_done)
            timer_next = timer_reg - 9'h001;
          else
          begin
            state_next = irm_pkg::IRM_ON;
            timer_next = {1'b0, width_reg} + irm_pkg::TIMER_EXTRA;
            phase_next = 2'h0;
          end
        end
        irm_pkg::IRM_IDLE: state_next = irm_pkg::IRM_IDLE;
        default: state_next = irm_pkg::IRM_IDLE;
      endcase
    end
    // pin follows the next state so it lines up with the timer
    out_n_next = !((state_next == irm_pkg::IRM_ON)
      && (!carrier_enable || !phase_next[1]));
  end

  // state registers, all frozen while the clock enable is low
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      state_reg <= irm_pkg::IRM_IDLE;
      width_reg <= irm_pkg::WIDTH_RESET;
      gap_reg <= irm_pkg::WIDTH_RESET;
      control_reg <= irm_pkg::CONTROL_RESET;
      count_hi_reg <= 2'h0;
      count_reg <= irm_pkg::COUNT_RESET;
      timer_reg <= 9'h000;
      phase_reg <= 2'h0;
      irq_reg <= 1'b0;
      out_n_reg <= 1'b1;
      wdt_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end
    else if (CE_I)
    begin
      state_reg <= state_next;
      width_reg <= width_next;
      gap_reg <= gap_next;
      control_reg <= control_next;
      count_hi_reg <= count_hi_next;
      count_reg <= count_next;
      timer_reg <= timer_next;
      phase_reg <= phase_next;
      irq_reg <= irq_next;
      out_n_reg <= out_n_next;
      wdt_reg <= wdt_next;
      rdata_reg <= rdata_next;
    end
  end

  assign DREG_RDATA_O = rdata_reg;
  assign MOD_OUT_N_O = out_n_reg;
  assign BURST_DONE_IRQ_O = irq_reg;
  assign WATCHDOG_RELOAD_O = wdt_reg;

  // helper: length of the current on or off phase, for the assertions
  logic [9:0] run_len_reg;
  logic [8:0] len_width;
  logic [8:0] len_gap;
  assign len_width = {1'b0, width_reg} + 9'(irm_pkg::EXTRA_CYCLES);
  assign len_gap = {1'b0, gap_reg} + 9'(irm_pkg::EXTRA_CYCLES);
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      run_len_reg <= 10'h000;
    else if (CE_I)
      run_len_reg <= (state_next != state_reg || load_count) ? 10'h001 : run_len_reg + 10'h001;
  end

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  a_idle_pin_high: assert property ((state_reg != irm_pkg::IRM_ON) |-> out_n_reg)
    else $error("pin active outside an on phase");
  a_burst_starts: assert property ((CE_I && load_count) |=> (state_reg == irm_pkg::IRM_ON)
    && (timer_reg == {1'b0, $past(width_reg)} + 9'h001))
    else $error("counter load did not start a pulse");
  a_on_length: assert property ((CE_I && state_reg == irm_pkg::IRM_ON && !load_count
    && !long_pulse_enable && state_next == irm_pkg::IRM_OFF) |-> (run_len_reg == {1'b0, len_width}))
    else $error("on phase length wrong");
  a_off_length: assert property ((CE_I && state_reg == irm_pkg::IRM_OFF && !load_count
    && state_next == irm_pkg::IRM_ON) |-> (run_len_reg == {1'b0, len_gap}))
    else $error("off phase length wrong");
  a_done_sets_flag: assert property ((CE_I && finish && !load_count) |=> irq_reg
    && (state_reg == irm_pkg::IRM_IDLE))
    else $error("burst end did not raise flag");
  a_clear_flag: assert property ((CE_I && wr_ctrl && DREG_WDATA_I[irm_pkg::BIT_CLR_IRQ] && !finish)
    |=> !irq_reg)
    else $error("flag not cleared by control write");
  a_wdt_strobe: assert property ((CE_I && wr_ctrl && DREG_WDATA_I[irm_pkg::BIT_WDT])
    |=> WATCHDOG_RELOAD_O)
    else $error("watchdog reload not pulsed");
  // the reload must be a single-cycle pulse, never a level
  a_wdt_one_cycle: assert property ((CE_I && !(wr_ctrl && DREG_WDATA_I[irm_pkg::BIT_WDT]))
    |=> !WATCHDOG_RELOAD_O)
    else $error("watchdog reload pulse stretched");
  a_ctrl_reserved: assert property ((control_reg & ~irm_pkg::CONTROL_STORE_MASK) == 8'h00)
    else $error("reserved or strobe bit stored");
  a_cont_no_end: assert property ((continuous_enable && state_reg != irm_pkg::IRM_IDLE)
    |=> (state_reg != irm_pkg::IRM_IDLE))
    else $error("continuous train stopped");
  a_long_no_gap: assert property ((long_pulse_enable && !load_count)
    |-> (state_next != irm_pkg::IRM_OFF || state_reg == irm_pkg::IRM_OFF))
    else $error("gap produced in long pulse mode");
  a_carrier_chop: assert property ((CE_I && carrier_enable && state_reg == irm_pkg::IRM_ON
    && state_next == irm_pkg::IRM_ON && !load_count && phase_next[1]) |=> out_n_reg)
    else $error("carrier low phase drove pin");

  c_full_burst: cover property (state_reg == irm_pkg::IRM_OFF ##[1:600] irq_reg);
  c_long_pulse: cover property (long_pulse_enable && finish);
  c_carrier: cover property (carrier_enable && $fell(out_n_reg) ##4 $fell(out_n_reg));
  c_clear: cover property (irq_reg ##1 !irq_reg);
endmodule

// File: sim/irm_cpu_model.sv
`timescale 1ns/1ps
// core side: one derivative-register transfer per wr_reg or rd_reg call, two per start_burst, driven 1 ns after the edge
module irm_cpu_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [2:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial
  begin
    addr_o = 3'h0;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // strobe is up for one edge only; data inverted after so stale bytes never match
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask
  // read data is registered at the strobe edge, taken just after it
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    d = rdata_i;
  endtask
  // high part first, the low-part write starts the burst; callers never pass zero
  task automatic start_burst(input logic [9:0] n);
    wr_reg(irm_pkg::ADDR_COUNT_HI, {6'h00, n[9:8]});
    wr_reg(irm_pkg::ADDR_COUNT_LO, n[7:0]);
  endtask
endmodule

// File: sim/ir_pulse_burst_modulator_bench.sv
`timescale 1ns/1ps
module ir_pulse_burst_modulator_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, rd_v;
  logic wr, rd, out_n, irq, wdt;
  int n_fail = 0;
  int comparisons = 0;
  int n_wdt = 0;
  int lows, falls;
  // cases: plain, wide count, long, carrier, long with carrier, continuous
  int ctl[6] = '{0, 0, 2, 1, 3, 4};
  int wid[6] = '{3, 0, 1, 5, 2, 0};
  int gap[6] = '{1, 0, 0, 0, 0, 0};
  int cnt[6] = '{2, 256, 3, 1, 2, 1};
  int exl[6] = '{10, 512, 9, 4, 4, 20};
  int exf[6] = '{2, 256, 1, 2, 2, 10};
  always #2.5 clk = ~clk;
  irm_modulator u_dut (.REF_CLK_I(clk), .RESET_N_I(rst_n), .CE_I(ce), .DREG_ADDR_I(addr),
    .DREG_WDATA_I(wdata), .DREG_WR_I(wr), .DREG_RD_I(rd), .DREG_RDATA_O(rdata),
    .MOD_OUT_N_O(out_n), .BURST_DONE_IRQ_O(irq), .WATCHDOG_RELOAD_O(wdt));
  irm_cpu_model u_cpu (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  // reload pulses counted so a stretched pulse shows up as an extra count
  always @(posedge clk)
    if (wdt === 1'b1)
      n_wdt++;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // counts low cycles and falling edges until done or the limit
  task automatic run_case(input int k);
    int lim;
    logic prev;
    lim = (k < 5) ? 1200 : 40;
    u_cpu.wr_reg(irm_pkg::ADDR_WIDTH_REG, 8'(wid[k]));
    u_cpu.wr_reg(irm_pkg::ADDR_GAP_REG, 8'(gap[k]));
    u_cpu.wr_reg(irm_pkg::ADDR_CONTROL, 8'(ctl[k]));
    u_cpu.start_burst(10'(cnt[k]));
    lows = 0;
    falls = 0;
    prev = 1'b1;
    for (int i = 0; i < lim && irq !== 1'b1; i++)
    begin
      lows += int'(out_n === 1'b0);
      falls += int'(out_n === 1'b0 && prev);
      prev = out_n;
      @(posedge clk);
      #1;
    end
    check(16'(lows), 16'(exl[k]));
    check(16'(falls), 16'(exf[k]));
    check(16'(irq), 16'(k < 5));
    $display("case %0d done", k);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check(16'(out_n), 16'h0001);
    check(16'(irq), 16'h0000);
    u_cpu.rd_reg(irm_pkg::ADDR_WIDTH_REG, rd_v);
    check(16'(rd_v), 16'h0000);
    for (int k = 0; k < 5; k++)
      run_case(k);
    // flag is still up: both strobes and the reserved bits in one write
    u_cpu.wr_reg(irm_pkg::ADDR_CONTROL, 8'hf8);
    repeat (2) @(posedge clk);
    #1;
    check(16'(irq), 16'h0000);
    check(16'(n_wdt), 16'h0001);
    u_cpu.rd_reg(irm_pkg::ADDR_CONTROL, rd_v);
    check(16'(rd_v), 16'h0000);
    u_cpu.wr_reg(irm_pkg::ADDR_CONTROL, 8'h07);
    u_cpu.rd_reg(irm_pkg::ADDR_CONTROL, rd_v);
    check(16'(rd_v), 16'h0007);
    u_cpu.rd_reg(3'h5, rd_v);
    check(16'(rd_v), 16'h0000);
    u_cpu.rd_reg(irm_pkg::ADDR_WIDTH_REG, rd_v);
    check(16'(rd_v), 16'h0002);
    $display("register test done");
    // enable low mid-pulse: frozen cycles must stretch the pin, bus kept idle meanwhile
    u_cpu.wr_reg(irm_pkg::ADDR_CONTROL, 8'h00);
    u_cpu.wr_reg(irm_pkg::ADDR_WIDTH_REG, 8'h03);
    u_cpu.start_burst(10'h001);
    repeat (2) @(posedge clk);
    #1;
    ce = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check(16'(out_n), 16'h0000);
    check(16'(irq), 16'h0000);
    ce = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(16'(out_n), 16'h0000);
    @(posedge clk);
    #1;
    check(16'(out_n), 16'h0001);
    check(16'(irq), 16'h0001);
    $display("clock enable test done");
    run_case(5);
    // reset in the middle of a continuous train must park the pin and clear the counter
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(16'(out_n), 16'h0001);
    rst_n = 1'b1;
    u_cpu.rd_reg(irm_pkg::ADDR_COUNT_LO, rd_v);
    check(16'(rd_v), 16'h0000);
    repeat (3) @(posedge clk);
    #1;
    check(16'(out_n), 16'h0001);
    check(16'(irq), 16'h0000);
    $display("mid-run reset test done");
    results();
  end
  // whole run is about 1200 cycles; allow well over that
  initial
  begin
    #30000;
    n_fail++;
    results();
  end
endmodule
